/* File: rtl/prescale_if.sv */
// Interface between the timer core and its prescaler
`default_nettype none
interface prescale_if;
   logic [2:0] sel;
   logic       tick;
   modport core (output sel, input tick);
   modport presc (input sel, output tick);
endinterface : prescale_if
`default_nettype wire

/* File: rtl/refresh_interval_timer.sv */
// Refresh interval timer with AXI4-Lite register slave and interrupt logic
`default_nettype none
// Summary of operation
// [RQ1] Select 000 halts; 001-011 divide by 2,8,32
// [RQ2] Select 100-111 divide by 128,512,2048,4096
// [RQ3] Request only with enable and flag set
// [RQ4] Flag sets when counter equals constant
// [RQ5] Reset and standby clear the flag
// [RQ6] Clear needs read-at-one then write zero
// [RQ7] Writing one to flag does nothing
// [RQ8] Software uses byte accesses only
// [RQ9] Counter restarts from zero after match
module refresh_interval_timer
   import refresh_timer_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rstn,
   input  wire logic              i_standby,
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic [1:0]             o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic [DATA_W-1:0]      o_rdata,
   output logic [1:0]             o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic                   o_match_interrupt,
   output logic                   o_irq,
   output logic                   o_refresh_req
);
   prescale_if psc ();

   logic              compare_match_flag_q;
   logic              match_irq_enable_q;
   logic [2:0]        count_clock_select_q;
   logic [7:0]        refresh_counter_q;
   logic [7:0]        refresh_constant_q;
   flag_state_t       flag_state_q;
   logic [IRQ_W-1:0]  irq_status_q;
   logic [IRQ_W-1:0]  irq_mask_q;

   logic              aw_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic              w_held_q;
   logic [DATA_W-1:0] w_data_q;
   logic [3:0]        w_strb_q;

   logic              wr_fire;
   logic              rd_fire;
   logic              wr_lane0;
   logic [7:0]        wbyte;
   logic [7:0]        csr_view;
   logic [DATA_W-1:0] rd_word;
   logic              rd_hit;
   logic              wr_hit;

   assign psc.sel = count_clock_select_q;

   refresh_prescaler u_presc (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_standby (i_standby),
      .p         (psc)
   );

   // Write channel: address and data taken in either order, one at a time
   assign wr_fire  = aw_held_q && w_held_q && !o_bvalid;
   assign wr_lane0 = w_strb_q[0];
   assign wbyte    = w_data_q[7:0];
   // Only byte lane 0 is honoured; wider strobes still update the low byte
   assign wr_hit   = (aw_addr_q == OFS_CTRL_STATUS) || (aw_addr_q == OFS_COUNTER) ||
                     (aw_addr_q == OFS_CONSTANT) || (aw_addr_q == OFS_IRQ_STATUS) ||
                     (aw_addr_q == OFS_IRQ_MASK); // see [RQ8]

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
         o_awready <= 1'b0;
      end else begin
         // No address taken while a response waits, so one write stays in flight
         o_awready <= !aw_held_q && !o_awready && !o_bvalid && i_awvalid;
         if (o_awready && i_awvalid) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= i_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         o_wready <= 1'b0;
      end else begin
         o_wready <= !w_held_q && !o_wready && !o_bvalid && i_wvalid;
         if (o_wready && i_wvalid) begin
            w_held_q <= 1'b1;
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_bvalid <= 1'b0;
         o_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         o_bvalid <= 1'b1;
         o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // Read channel
   assign csr_view = {compare_match_flag_q, match_irq_enable_q, count_clock_select_q, CSR_LOW_RESERVED};

   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      case (i_araddr)
         OFS_CTRL_STATUS: rd_word[7:0] = csr_view;
         OFS_COUNTER:     rd_word[7:0] = refresh_counter_q;
         OFS_CONSTANT:    rd_word[7:0] = refresh_constant_q;
         OFS_IRQ_STATUS:  rd_word[IRQ_W-1:0] = irq_status_q;
         OFS_IRQ_MASK:    rd_word[IRQ_W-1:0] = irq_mask_q;
         default:         rd_hit = 1'b0;
      endcase
   end

   assign rd_fire = o_arready && i_arvalid;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= '0;
         o_rresp   <= RESP_OKAY;
      end else begin
         o_arready <= !o_arready && !o_rvalid && i_arvalid;
         if (rd_fire) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_word;
            o_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // Counter: the count after a match restarts at zero, so the period is constant plus one ticks
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         refresh_counter_q <= COUNTER_RESET;
      end else if (i_standby) begin
         refresh_counter_q <= COUNTER_RESET;
      end else if (wr_fire && wr_lane0 && aw_addr_q == OFS_COUNTER) begin
         refresh_counter_q <= wbyte;
      end else if (psc.tick) begin
         if (refresh_counter_q == refresh_constant_q) begin
            refresh_counter_q <= COUNTER_RESET; // see [RQ9]
         end else begin
            refresh_counter_q <= refresh_counter_q + 8'h01;
         end
      end
   end

   // Compare is evaluated when the counter first holds the constant value
   logic at_const_q;
   logic first_equal;
   assign first_equal = (refresh_counter_q == refresh_constant_q) && !at_const_q;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         at_const_q <= 1'b0;
      end else begin
         at_const_q <= (refresh_counter_q == refresh_constant_q);
      end
   end

   // Control fields
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         match_irq_enable_q   <= CSR_RESET[BIT_MATCH_IRQ_ENABLE];
         count_clock_select_q <= CSR_RESET[BIT_CKS_H:BIT_CKS_L];
         refresh_constant_q   <= CONSTANT_RESET;
         irq_mask_q           <= '0;
      end else if (wr_fire && wr_lane0) begin
         if (aw_addr_q == OFS_CTRL_STATUS) begin
            match_irq_enable_q   <= wbyte[BIT_MATCH_IRQ_ENABLE];
            count_clock_select_q <= wbyte[BIT_CKS_H:BIT_CKS_L];
         end
         if (aw_addr_q == OFS_CONSTANT) begin
            refresh_constant_q <= wbyte;
         end
         if (aw_addr_q == OFS_IRQ_MASK) begin
            irq_mask_q <= wbyte[IRQ_W-1:0];
         end
      end
   end

   // Flag clear is armed by a read that saw it set
   logic flag_set;
   logic flag_clear;
   assign flag_set   = first_equal && !i_standby; // see [RQ4]
   assign flag_clear = wr_fire && wr_lane0 && (aw_addr_q == OFS_CTRL_STATUS) &&
                       !wbyte[BIT_CMF] && (flag_state_q == FLAG_ARMED); // see [RQ6] see [RQ7]

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         flag_state_q <= FLAG_IDLE;
      end else if (i_standby || flag_clear) begin
         flag_state_q <= FLAG_IDLE;
      end else begin
         case (flag_state_q)
            FLAG_IDLE: begin
               if (rd_fire && i_araddr == OFS_CTRL_STATUS && compare_match_flag_q) begin
                  flag_state_q <= FLAG_ARMED; // see [RQ6]
               end
            end
            FLAG_ARMED: flag_state_q <= FLAG_ARMED;
            default:    flag_state_q <= FLAG_IDLE;
         endcase
      end
   end

   // New match wins over a clear in the same cycle
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         compare_match_flag_q <= 1'b0; // see [RQ5]
      end else if (i_standby) begin
         compare_match_flag_q <= 1'b0; // see [RQ5]
      end else if (flag_set) begin
         compare_match_flag_q <= 1'b1; // see [RQ4]
      end else if (flag_clear) begin
         compare_match_flag_q <= 1'b0; // see [RQ6]
      end
   end

   // Sticky status, write one to clear; set wins
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_status_q <= '0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if (i == IRQ_BIT_MATCH && flag_set) begin
               irq_status_q[i] <= 1'b1;
            end else if (wr_fire && wr_lane0 && aw_addr_q == OFS_IRQ_STATUS && wbyte[i]) begin
               irq_status_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_match_interrupt <= 1'b0;
         o_irq             <= 1'b0;
         o_refresh_req     <= 1'b0;
      end else begin
         o_match_interrupt <= match_irq_enable_q && compare_match_flag_q; // see [RQ3]
         o_irq             <= |(irq_status_q & irq_mask_q);
         o_refresh_req     <= flag_set;
      end
   end

endmodule : refresh_interval_timer
`default_nettype wire

/* File: rtl/refresh_prescaler.sv */
// Free-running prescaler producing one count tick per selected period
`default_nettype none
module refresh_prescaler
   import refresh_timer_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_rstn,
   input  wire logic i_standby,
   prescale_if.presc p
);
   logic [PRESC_W-1:0] div_q;
   logic [PRESC_W-1:0] mask;

   // Tick when the low bits wrap: period is 2,8,32,128,512,2048,4096
   always_comb begin
      case (p.sel)
         3'h1:    mask = 12'h001; // see [RQ1]
         3'h2:    mask = 12'h007; // see [RQ1]
         3'h3:    mask = 12'h01f; // see [RQ1]
         3'h4:    mask = 12'h07f; // see [RQ2]
         3'h5:    mask = 12'h1ff; // see [RQ2]
         3'h6:    mask = 12'h7ff; // see [RQ2]
         3'h7:    mask = 12'hfff; // see [RQ2]
         default: mask = 12'h000;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_q <= '0;
      end else if (i_standby) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 12'h001;
      end
   end

   // Halt select never ticks
   assign p.tick = (p.sel != CKS_HALT) && ((div_q & mask) == mask); // see [RQ1]
endmodule : refresh_prescaler
`default_nettype wire

/* File: rtl/refresh_timer_pkg.sv */
// Package: register map, field positions and timing constants of the refresh timer
`default_nettype none
package refresh_timer_pkg;
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 32;
   // Byte addresses on the register bus
   localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 20'hee028;
   localparam logic [ADDR_W-1:0] OFS_COUNTER     = 20'hee02c;
   localparam logic [ADDR_W-1:0] OFS_CONSTANT    = 20'hee030;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 20'hee034;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 20'hee038;
   // Control/status fields
   localparam int unsigned BIT_CMF   = 7;
   localparam int unsigned BIT_MATCH_IRQ_ENABLE  = 6;
   localparam int unsigned BIT_CKS_H = 5;
   localparam int unsigned BIT_CKS_L = 3;
   localparam logic [2:0]  CSR_LOW_RESERVED = 3'h7;
   localparam logic [7:0]  CSR_RESET = 8'h07;
   localparam logic [7:0]  CONSTANT_RESET = 8'hff;
   localparam logic [7:0]  COUNTER_RESET  = 8'h00;
   // Prescaler
   localparam int unsigned PRESC_W = 12;
   localparam logic [2:0] CKS_HALT = 3'h0;
   // Interrupt status bits
   localparam int unsigned IRQ_BIT_MATCH = 0;
   localparam int unsigned IRQ_W         = 1;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {FLAG_IDLE, FLAG_ARMED} flag_state_t;
endpackage : refresh_timer_pkg
`default_nettype wire

/* File: tb/dram_refresh_interval_timer_tb.sv */
// Register-level testbench for the refresh interval timer
`default_nettype none
module dram_refresh_interval_timer_tb;
   import refresh_timer_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk, rstn, standby, awvalid, wvalid, bready, arvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, v;
   logic [1:0]        r;
   logic              awready, wready, bvalid, arready, rvalid, mirq, irq, req;
   logic [1:0]        bresp, rresp;
   logic [3:0]        wstrb;
   logic [DATA_W-1:0] rdata;
   int                fail_count, checks, c;
   int                div [8] = '{0, 2, 8, 32, 128, 512, 2048, 4096};
   always #10 clk = ~clk;
   refresh_interval_timer refresh_interval_timer_inst (.i_sys_clk(clk), .i_rstn(rstn), .i_standby(standby),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
      .o_rvalid(rvalid), .i_rready(rready), .o_match_interrupt(mirq), .o_irq(irq), .o_refresh_req(req));
   task automatic close_out;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic timeout;
      fail_count++;
      $display("ERROR wait expected answer seen timeout");
      close_out();
   endtask : timeout
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY,
                     input logic [3:0] st = 4'h1);
      int n;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      if (n == 100)
         timeout();
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] rr);
      int n;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      if (n == 100)
         timeout();
      d = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      rd(a, v, r);
      chk("rdata", e, v);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask : rc
   task automatic wait_req;
      for (c = 1; c < 6000; c++) begin
         @(posedge clk);
         if (req === 1'b1)
            break;
      end
      if (c == 6000)
         timeout();
   endtask : wait_req
   initial begin
      {clk, rstn, standby, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb, fail_count, checks} = '0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rc(OFS_CTRL_STATUS, 32'h07);
      rc(OFS_CONSTANT, 32'hff);
      rc(OFS_COUNTER, 32'h0);
      rc(OFS_IRQ_MASK, 32'h0);
      rc(OFS_IRQ_STATUS, 32'h0);
      rc(20'hee03c, 32'h0, RESP_SLVERR);
      wr(20'hee040, 8'hff, RESP_SLVERR);
      wr(OFS_CONSTANT, 8'h55, RESP_OKAY, 4'h0);
      rc(OFS_CONSTANT, 32'hff);
      $display("test reset done");
      wr(OFS_CTRL_STATUS, 8'h00);
      wr(OFS_COUNTER, 8'h00);
      repeat (100) @(posedge clk);
      rc(OFS_COUNTER, 32'h0);
      for (int s = 1; s < 8; s++) begin
         wr(OFS_CTRL_STATUS, {2'b0, s[2:0], 3'b0});
         wr(OFS_COUNTER, 8'h00);
         repeat (8 * div[s]) @(posedge clk);
         rd(OFS_COUNTER, v, r);
         // Free-running prescaler phase and bus latency widen the window
         checks++;
         if ((v >= 7 && v <= 9 + 12 / div[s]) !== 1'b1) begin
            fail_count++;
            $display("ERROR counter for select %0d expected 7..%0d seen %h", s, 9 + 12 / div[s], v);
         end
      end
      $display("test prescaler done");
      wr(OFS_CTRL_STATUS, 8'h00);
      wr(OFS_CONSTANT, 8'h03);
      wr(OFS_COUNTER, 8'h00);
      wr(OFS_CTRL_STATUS, 8'h08);
      wait_req();
      wait_req();
      chk("match period", 32'd8, c);
      chk("match_interrupt off", 32'h0, {31'h0, mirq});
      chk("irq masked", 32'h0, {31'h0, irq});
      rc(OFS_IRQ_STATUS, 32'h1);
      wr(OFS_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      wr(OFS_CTRL_STATUS, 8'h48);
      repeat (2) @(posedge clk);
      chk("match_interrupt on", 32'h1, {31'h0, mirq});
      wr(OFS_CTRL_STATUS, 8'hc0);
      wr(OFS_COUNTER, 8'h00);
      rc(OFS_CTRL_STATUS, 32'hc7);
      wr(OFS_CTRL_STATUS, 8'h40);
      rc(OFS_CTRL_STATUS, 32'h47);
      chk("match_interrupt cleared", 32'h0, {31'h0, mirq});
      wr(OFS_CTRL_STATUS, 8'hc0);
      rc(OFS_CTRL_STATUS, 32'h47);
      wr(OFS_IRQ_STATUS, 8'h01);
      rc(OFS_IRQ_STATUS, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test match done");
      wr(OFS_CTRL_STATUS, 8'h48);
      wait_req();
      @(posedge clk);
      standby <= 1'b1;
      rc(OFS_CTRL_STATUS, 32'h4f);
      rc(OFS_COUNTER, 32'h0);
      chk("match_interrupt standby", 32'h0, {31'h0, mirq});
      @(posedge clk);
      standby <= 1'b0;
      $display("test standby done");
      wait_req();
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rc(OFS_CTRL_STATUS, 32'h07);
      chk("match_interrupt reset", 32'h0, {31'h0, mirq});
      $display("test mid-run reset done");
      close_out();
   end
endmodule : dram_refresh_interval_timer_tb
`default_nettype wire

/* File: tb/refresh_timer_checker.sv */
// Port-level assertions for the refresh interval timer
`default_nettype none
module refresh_timer_checker
   import refresh_timer_pkg::*;
(
   input wire logic              i_sys_clk,
   input wire logic              i_rstn,
   input wire logic              i_standby,
   input wire logic              i_arvalid,
   input wire logic              i_rready,
   input wire logic              i_bready,
   input wire logic              o_arready,
   input wire logic              o_awready,
   input wire logic              o_wready,
   input wire logic              o_bvalid,
   input wire logic [1:0]        o_bresp,
   input wire logic              o_rvalid,
   input wire logic [1:0]        o_rresp,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic              o_match_interrupt,
   input wire logic              o_refresh_req
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   // Flag set fires only on the first cycle the counter equals the constant, so a request never spans two
   AST_REQ_PULSE: assert property (o_refresh_req |=> !o_refresh_req)
      else $error("refresh request longer than one cycle");
   // Three cycles of standby let the two-cycle lag (flag register, then output register) drain
   AST_STANDBY_FLAG: assert property (i_standby [*3] |-> !o_match_interrupt)
      else $error("match interrupt during standby");
   AST_STANDBY_REQ: assert property (i_standby [*2] |-> !o_refresh_req)
      else $error("refresh request during standby");
   AST_IRQ_CAUSE: assert property ($rose(o_match_interrupt) |->
      $past(o_refresh_req) || $past(o_refresh_req, 2) ||
      $past(o_refresh_req, 3) || o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2) || $past(o_bvalid, 3))
      else $error("match interrupt rose without match or write");
   AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before taken");
   AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped before taken");
   AST_B_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("new write taken while response pending");
   AST_R_ANSWER: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   AST_R_ERRDATA: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == '0)
      else $error("error read returned data");
   AST_R_UPPER: assert property (o_rvalid |-> o_rdata[DATA_W-1:8] == '0)
      else $error("upper read bytes not zero");
endmodule : refresh_timer_checker
bind refresh_interval_timer refresh_timer_checker refresh_timer_checker_inst (.i_sys_clk, .i_rstn, .i_standby,
   .i_arvalid, .i_rready, .i_bready, .o_arready, .o_awready, .o_wready, .o_bvalid, .o_bresp, .o_rvalid,
   .o_rresp, .o_rdata, .o_match_interrupt, .o_refresh_req);
`default_nettype wire
